// [design/twf_slave.sv]
// two-wire slave flag and clock-hold core with AXI4-Lite registers
// Summary of operation
// - start conditions should clear transmit collision flag
// - only plain start clears it, repeated start not
// - clear colliding with address set keeps hold
// - timeout coinciding with start drops transaction
// - respond command clears data flag cycle later
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`include "twf_defs.svh"
module twf_slave
#(
  parameter int AW = 8,
  parameter int TIMEOUT_CYC = `TWF_TIMEOUT_US * `TWF_CLK_MHZ
)
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [AW-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [AW-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_scl,
  output logic o_scl_out,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_irq
);
  twf_line_if lines ();
  twf_cond u_cond (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .lines(lines)
  );

  // ****************************************
  // register bus
  // ****************************************
  logic aw_have, w_have;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_en;
  logic [1:0] ctrl;
  logic [6:0] own_addr;
  logic [7:0] tx_data, rx_data;
  logic [`TWF_EV_W-1:0] irq_stat, irq_mask, ev;

  assign wr_en = aw_have & w_have & ~o_bvalid;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= `TWF_RESP_OKAY;
      wr_addr <= '0;
      wr_data <= 32'h0000_0000;
    end
    else
    begin
      if (i_awvalid & o_awready)
      begin
        aw_have <= 1'b1;
        wr_addr <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid & o_wready)
      begin
        w_have <= 1'b1;
        wr_data <= i_wstrb[0] ? i_wdata : 32'h0000_0000;
        o_wready <= 1'b0;
      end
      if (wr_en)
      begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= (wr_addr > `TWF_OFF_IRQ_MASK || wr_addr[1:0] != 2'h0)
                   ? `TWF_RESP_SLVERR : `TWF_RESP_OKAY;
      end
      if (o_bvalid & i_bready)
      begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // byte lane 0 carries every field; a write without lane 0 stores zeros
  logic wr_ctrl, wr_addr_r, wr_stat, wr_cmd, wr_data_r, wr_istat, wr_imask;
  assign wr_ctrl = wr_en & wr_addr == `TWF_OFF_CTRL;
  assign wr_addr_r = wr_en & wr_addr == `TWF_OFF_OWN_ADDR;
  assign wr_stat = wr_en & wr_addr == `TWF_OFF_STATUS;
  assign wr_cmd = wr_en & wr_addr == `TWF_OFF_CMD;
  assign wr_data_r = wr_en & wr_addr == `TWF_OFF_DATA;
  assign wr_istat = wr_en & wr_addr == `TWF_OFF_IRQ_STAT;
  assign wr_imask = wr_en & wr_addr == `TWF_OFF_IRQ_MASK;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      ctrl <= `TWF_RST_CTRL;
      own_addr <= `TWF_RST_ADDR;
      tx_data <= 8'h00;
      irq_mask <= `TWF_RST_MASK;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= wr_data[1:0];
      if (wr_addr_r)
        own_addr <= wr_data[6:0];
      if (wr_data_r)
        tx_data <= wr_data[7:0];
      if (wr_imask)
        irq_mask <= wr_data[`TWF_EV_W-1:0];
    end
  end

  // ****************************************
  // bus state and timeout
  // ****************************************
  twf_pkg::twf_state_e state;
  twf_pkg::twf_bus_e bus;
  logic en, busy, to_fire;
  logic [15:0] to_cnt;
  assign en = ctrl[`TWF_CTRL_EN];
  assign busy = bus == twf_pkg::TWF_BUS_BUSY;
  assign to_fire = ctrl[`TWF_CTRL_TO_EN] & busy
                   & to_cnt == 16'(TIMEOUT_CYC - 1);

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      bus <= twf_pkg::TWF_BUS_UNKNOWN;
      to_cnt <= 16'h0000;
    end
    else
    begin
      if (lines.start & ~to_fire)
        bus <= twf_pkg::TWF_BUS_BUSY;
      else if (lines.stop | to_fire)
        bus <= twf_pkg::TWF_BUS_IDLE;
      if (~busy | ~lines.scl | lines.start | lines.stop | to_fire)
        to_cnt <= 16'h0000;
      else
        to_cnt <= to_cnt + 16'h0001;
    end
  end

  // ****************************************
  // slave sequencer
  // ****************************************
  logic [7:0] sh;
  logic [3:0] bit_cnt;
  logic dir, mack, hold, addr_flag, data_flag, coll, data_clr_pend;
  logic addr_hit, set_data, set_addr, clr_addr, rel_addr, resp_go, resp_end;
  logic stop_ev, coll_set;

  assign addr_hit = state == twf_pkg::TWF_ADDR & lines.scl_fall
                    & bit_cnt == 4'h8 & sh[7:1] == own_addr;
  assign set_data = (state == twf_pkg::TWF_RX & lines.scl_fall
                    & bit_cnt == 4'h8)
                   | (state == twf_pkg::TWF_TXACK & lines.scl_fall & ~mack);
  assign stop_ev = lines.stop & state != twf_pkg::TWF_IDLE;
  assign set_addr = addr_hit | stop_ev;
  assign clr_addr = wr_stat & wr_data[`TWF_ST_ADDR_FLAG];
  assign rel_addr = clr_addr & ~set_addr & state == twf_pkg::TWF_AHOLD;
  assign resp_go = wr_cmd & wr_data[1:0] == `TWF_CMD_RESPOND
                   & state == twf_pkg::TWF_DHOLD;
  assign resp_end = wr_cmd & wr_data[1:0] == `TWF_CMD_COMPLETE
                    & state == twf_pkg::TWF_DHOLD;
  assign coll_set = state == twf_pkg::TWF_TX & lines.scl_rise
                    & ~o_sda_oe & ~lines.sda;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      state <= twf_pkg::TWF_IDLE;
      sh <= 8'h00;
      bit_cnt <= 4'h0;
      dir <= 1'b0;
      mack <= 1'b1;
      rx_data <= 8'h00;
      o_sda_oe <= 1'b0;
    end
    else if (~en | lines.stop | to_fire)
    begin
      state <= twf_pkg::TWF_IDLE;
      o_sda_oe <= 1'b0;
    end
    else if (lines.start)
    begin
      state <= twf_pkg::TWF_ADDR;
      bit_cnt <= 4'h0;
      o_sda_oe <= 1'b0;
    end
    else
    begin
      unique case (state)
        twf_pkg::TWF_IDLE: ;
        twf_pkg::TWF_ADDR, twf_pkg::TWF_RX:
        begin
          if (lines.scl_rise)
          begin
            sh <= {sh[6:0], lines.sda};
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (lines.scl_fall & bit_cnt == 4'h8)
          begin
            if (state == twf_pkg::TWF_RX)
            begin
              rx_data <= sh;
              state <= twf_pkg::TWF_DHOLD;
            end
            else if (addr_hit)
            begin
              dir <= sh[0];
              state <= twf_pkg::TWF_AHOLD;
            end
            else
              state <= twf_pkg::TWF_IDLE;
          end
        end
        twf_pkg::TWF_AHOLD:
          if (rel_addr)
          begin
            state <= twf_pkg::TWF_ACK;
            o_sda_oe <= 1'b1;
          end
        twf_pkg::TWF_ACK:
          if (lines.scl_fall)
          begin
            bit_cnt <= 4'h0;
            sh <= tx_data;
            state <= dir ? twf_pkg::TWF_TX : twf_pkg::TWF_RX;
            o_sda_oe <= dir & ~tx_data[7];
          end
        twf_pkg::TWF_TX:
          if (lines.scl_fall)
          begin
            if (bit_cnt == 4'h7)
            begin
              state <= twf_pkg::TWF_TXACK;
              o_sda_oe <= 1'b0;
            end
            else
            begin
              bit_cnt <= bit_cnt + 4'h1;
              sh <= {sh[6:0], 1'b0};
              o_sda_oe <= ~sh[6];
            end
          end
        twf_pkg::TWF_TXACK:
          if (lines.scl_rise)
            mack <= lines.sda;
          else if (lines.scl_fall)
            state <= mack ? twf_pkg::TWF_IDLE : twf_pkg::TWF_DHOLD;
        twf_pkg::TWF_DHOLD:
          if (resp_end)
            state <= twf_pkg::TWF_IDLE;
          else if (resp_go & dir)
          begin
            bit_cnt <= 4'h0;
            sh <= tx_data;
            state <= twf_pkg::TWF_TX;
            o_sda_oe <= ~tx_data[7];
          end
          else if (resp_go)
          begin
            state <= twf_pkg::TWF_ACK;
            o_sda_oe <= ~wr_data[`TWF_CMD_NACK];
          end
      endcase
    end
  end

  // ****************************************
  // flags and clock hold
  // ****************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      hold <= 1'b0;
      addr_flag <= 1'b0;
      data_flag <= 1'b0;
      data_clr_pend <= 1'b0;
      coll <= 1'b0;
    end
    else
    begin
      if (addr_hit | set_data)
        hold <= 1'b1;
      else if (rel_addr | resp_go | resp_end | ~en)
        hold <= 1'b0;
      addr_flag <= set_addr | (addr_flag & ~clr_addr);
      data_clr_pend <= resp_go;
      data_flag <= set_data | (data_flag & ~data_clr_pend
             & ~(wr_stat & wr_data[`TWF_ST_DATA_FLAG]));
      coll <= coll_set | (coll & ~(lines.start & ~busy)
              & ~(wr_stat & wr_data[`TWF_ST_COLL]));
    end
  end

  assign ev = {coll_set, to_fire, set_data, stop_ev, addr_hit};

  // ****************************************
  // interrupt, pins and read port
  // ****************************************
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (i_araddr)
      `TWF_OFF_CTRL: rd_mux[1:0] = ctrl;
      `TWF_OFF_OWN_ADDR: rd_mux[6:0] = own_addr;
      `TWF_OFF_STATUS:
        rd_mux[7:0] = {bus, 1'b0, dir, coll, hold, addr_flag, data_flag};
      `TWF_OFF_DATA: rd_mux[7:0] = rx_data;
      `TWF_OFF_IRQ_STAT: rd_mux[`TWF_EV_W-1:0] = irq_stat;
      `TWF_OFF_IRQ_MASK: rd_mux[`TWF_EV_W-1:0] = irq_mask;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      irq_stat <= '0;
      o_irq <= 1'b0;
      o_scl_oe <= 1'b0;
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `TWF_RESP_OKAY;
    end
    else
    begin
      // set wins over a write-one clear
      irq_stat <= ev | (irq_stat & ~(wr_istat ? wr_data[`TWF_EV_W-1:0] : '0));
      o_irq <= |(irq_stat & irq_mask);
      o_scl_oe <= hold;
      if (i_arvalid & o_arready)
      begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rdata <= rd_mux;
        o_rresp <= (i_araddr > `TWF_OFF_IRQ_MASK || i_araddr[1:0] != 2'h0)
                   ? `TWF_RESP_SLVERR : `TWF_RESP_OKAY;
      end
      else if (o_rvalid & i_rready)
      begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  a_plain_start_coll: assert property (
    lines.start & ~busy & ~coll_set |=> ~coll)
    else $error("plain start left collision flag set");
  a_rep_start_coll: assert property (
    lines.start & busy & coll & ~wr_stat |=> coll)
    else $error("repeated start cleared collision flag");
  a_addr_hold: assert property (
    addr_hit |=> addr_flag & hold ##1 o_scl_oe)
    else $error("address match did not hold clock");
  a_clash_hold: assert property (
    addr_hit & clr_addr |=> hold & addr_flag)
    else $error("clear on set cycle released hold");
  a_clear_release: assert property (
    rel_addr |=> ~hold ##1 ~o_scl_oe)
    else $error("flag clear did not release clock");
  a_tout_drop: assert property (
    to_fire & lines.start & en |=> state == twf_pkg::TWF_IDLE)
    else $error("start kept on timeout cycle");
  a_dif_late: assert property (
    resp_go & data_flag |=> data_flag ##1 ~data_flag)
    else $error("data flag not cleared one cycle late");
  a_irq_level: assert property (
    $rose(|(irq_stat & irq_mask)) |=> o_irq)
    else $error("interrupt output missed");

  c_addr_hit: cover property (addr_hit);
  c_clash: cover property (addr_hit & clr_addr);
  c_tout_start: cover property (to_fire & lines.start);
  c_resp: cover property (resp_go ##2 ~data_flag);
endmodule : twf_slave

// [common/twf_defs.svh]
// register map, field positions, reset values and timing of the flag block
`ifndef TWF_DEFS_SVH
`define TWF_DEFS_SVH
`define TWF_OFF_CTRL 8'h00
`define TWF_OFF_OWN_ADDR 8'h04
`define TWF_OFF_STATUS 8'h08
`define TWF_OFF_CMD 8'h0C
`define TWF_OFF_DATA 8'h10
`define TWF_OFF_IRQ_STAT 8'h14
`define TWF_OFF_IRQ_MASK 8'h18
`define TWF_CTRL_EN 0
`define TWF_CTRL_TO_EN 1
`define TWF_ST_DATA_FLAG 0
`define TWF_ST_ADDR_FLAG 1
`define TWF_ST_HOLD 2
`define TWF_ST_COLL 3
`define TWF_ST_DIR 4
`define TWF_ST_BUS_LO 6
`define TWF_CMD_NACK 2
`define TWF_EV_ADDR 0
`define TWF_EV_STOP 1
`define TWF_EV_DATA 2
`define TWF_EV_TOUT 3
`define TWF_EV_COLL 4
`define TWF_EV_W 5
`define TWF_CMD_RESPOND 2'h3
`define TWF_CMD_COMPLETE 2'h2
`define TWF_RST_CTRL 2'h0
`define TWF_RST_ADDR 7'h00
`define TWF_RST_MASK 5'h00
`define TWF_RESP_OKAY 2'h0
`define TWF_RESP_SLVERR 2'h2
`define TWF_CLK_MHZ 10
`define TWF_TIMEOUT_US 25
`endif

// [common/twf_pkg.sv]
// types shared by the two-wire flag block
package twf_pkg;
  typedef enum logic [2:0] {
    TWF_IDLE = 3'h0,
    TWF_ADDR = 3'h1,
    TWF_AHOLD = 3'h2,
    TWF_ACK = 3'h3,
    TWF_RX = 3'h4,
    TWF_TX = 3'h5,
    TWF_TXACK = 3'h6,
    TWF_DHOLD = 3'h7
  } twf_state_e;
  typedef enum logic [1:0] {
    TWF_BUS_UNKNOWN = 2'h0,
    TWF_BUS_IDLE = 2'h1,
    TWF_BUS_BUSY = 2'h2
  } twf_bus_e;
endpackage : twf_pkg

// [common/twf_line_if.sv]
// synchronised line levels and bus conditions between detector and core
interface twf_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport det (output scl, sda, scl_rise, scl_fall, start, stop);
  modport core (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface : twf_line_if

// [design/twf_cond.sv]
// pin synchroniser and start/stop/edge detector for the two-wire lines
module twf_cond
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_sda,
  twf_line_if.det lines
);
  // index 0 is scl, index 1 is sda
  logic [1:0] meta;
  logic [1:0] sync;
  logic [1:0] prev;

  // first stage feeds only the second stage
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      meta <= 2'h3;
      sync <= 2'h3;
      prev <= 2'h3;
    end
    else
    begin
      meta <= {i_sda, i_scl};
      sync <= meta;
      prev <= sync;
    end
  end

  assign lines.scl = sync[0];
  assign lines.sda = sync[1];
  assign lines.scl_rise = sync[0] & ~prev[0];
  assign lines.scl_fall = ~sync[0] & prev[0];
  // sda moving while scl stays high marks a bus condition
  assign lines.start = sync[0] & prev[0] & prev[1] & ~sync[1];
  assign lines.stop = sync[0] & prev[0] & ~prev[1] & sync[1];
endmodule : twf_cond

// [sim/twf_mst_model.sv]
// behavioural two-wire bus master driving open-drain lines
module twf_mst_model
(
  input wire logic i_sys_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_low,
  output logic o_sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // line sequencing
  // ****************
  initial
  begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end
  task half();
    repeat (4) @(posedge i_sys_clk);
  endtask : half
  // the slave may stretch the low phase, so follow the wire itself
  task rise();
    o_scl_low <= 1'b0;
    for (int n = 0; n < 3000 && i_scl !== 1'b1; n++) @(posedge i_sys_clk);
    half();
  endtask : rise
  task start();
    o_sda_low <= 1'b0;
    half();
    rise();
    o_sda_low <= 1'b1;
    half();
    o_scl_low <= 1'b1;
    half();
  endtask : start
  task stop();
    o_sda_low <= 1'b1;
    half();
    rise();
    o_sda_low <= 1'b0;
    half();
  endtask : stop
  task bit_io(input logic b, output logic got);
    o_sda_low <= !b;
    half();
    rise();
    got = i_sda;
    o_scl_low <= 1'b1;
    @(posedge i_sys_clk);
  endtask : bit_io
  task xfer(input logic [7:0] d, output logic [7:0] got, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], got[i]);
    bit_io(1'b1, ack);
  endtask : xfer
  // clock left high with no condition, so only a timeout ends it
  task float_high(input int n);
    o_scl_low <= 1'b0;
    repeat (n) @(posedge i_sys_clk);
    o_scl_low <= 1'b1;
    @(posedge i_sys_clk);
  endtask : float_high
endmodule : twf_mst_model

// [sim/twf_slave_tb_top.sv]
// self-checking bench for the two-wire flag block
`include "twf_defs.svh"
module twf_slave_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {string n; logic [31:0] d; logic [31:0] m; logic [1:0] r;}
    twf_exp_s;
  localparam logic [7:0] A_CT = `TWF_OFF_CTRL;
  localparam logic [7:0] A_ST = `TWF_OFF_STATUS;
  localparam logic [7:0] A_IS = `TWF_OFF_IRQ_STAT;
  localparam logic [7:0] A_IM = `TWF_OFF_IRQ_MASK;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [1:0] bresp, rresp;
  logic scl_oe, sda_oe, m_scl_lo, m_sda_lo, ack, scl_out, sda_out;
  logic [7:0] got, dat;
  wire scl = !(scl_oe | m_scl_lo);
  wire sda = !(sda_oe | m_sda_lo);
  twf_exp_s expq[$];
  twf_exp_s e;
  int err_count = 0, checks_done = 0, cyc = 0, seed = 2;
  always #50 clk = ~clk;
  twf_slave #(.TIMEOUT_CYC(20)) dut (.i_sys_clk(clk), .i_srst(srst),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
    .i_wstrb(4'hF), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
    .i_scl(scl), .o_scl_out(scl_out), .o_scl_oe(scl_oe), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_irq(irq));
  twf_mst_model m (.i_sys_clk(clk), .i_scl(scl), .i_sda(sda),
    .o_scl_low(m_scl_lo), .o_sda_low(m_sda_lo));
  // ****************
  // checking
  // ****************
  task cmp(input string n, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x)
    begin
      $display("unexpected %s: expected %h seen %h", n, x, g);
      err_count++;
    end
  endtask : cmp
  task test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  always @(posedge clk)
  begin
    if (rvalid === 1'b1 && rready === 1'b1)
    begin
      e = expq.pop_front();
      if (e.m != 0)
      begin
        cmp(e.n, e.d, rdata & e.m);
        cmp({e.n, " resp"}, {30'h0, e.r}, {30'h0, rresp});
      end
    end
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_count++;
      test_done();
    end
  end
  // ****************
  // bus tasks
  // ****************
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    cmp("bresp", 32'h0, {30'h0, bresp});
    bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input string n, input logic [31:0] d,
    input logic [31:0] mk, input logic [1:0] r);
    expq.push_back('{n, d, mk, r});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    rready <= 1'b0;
  endtask : rd
  task wait_st(input int b);
    for (int i = 0; i < 300; i++)
    begin
      rd(A_ST, "", 32'h0, 32'h0, 2'h0);
      if (v[b] === 1'b1)
        break;
    end
  endtask : wait_st
  task note(input string n);
    $display("test %s done", n);
  endtask : note
  // ****************
  // scenarios
  // ****************
  initial
  begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(A_CT, "ctrl", 32'h0, 32'hFFFFFFFF, 2'h0);
    rd(A_ST, "status", 32'h0, 32'hFFFFFFFF, 2'h0);
    rd(A_IM, "mask", 32'h0, 32'hFFFFFFFF, 2'h0);
    rd(8'h1C, "unmapped", 32'h0, 32'hFFFFFFFF, `TWF_RESP_SLVERR);
    cmp("line outs", 32'h0, {30'h0, scl_out, sda_out});
    wr(A_CT, 32'h1);
    wr(`TWF_OFF_OWN_ADDR, 32'h2A);
    wr(A_IM, 32'h1F);
    note("reset");
    dat = 8'($random(seed));
    fork
      begin
        m.start();
        m.xfer(8'h54, got, ack);
        m.xfer(dat, got, ack);
      end
      begin
        wait_st(`TWF_ST_ADDR_FLAG);
        rd(A_ST, "addr status", 32'h86, 32'hFF, 2'h0);
        cmp("irq", 32'h1, {31'h0, irq});
        wr(A_ST, 32'h2);
        wait_st(`TWF_ST_DATA_FLAG);
        rd(`TWF_OFF_DATA, "data", {24'h0, dat}, 32'hFF, 2'h0);
        rd(A_IS, "irq stat", 32'h5, 32'h7, 2'h0);
        wr(A_IM, 32'h0);
        repeat (3) @(posedge clk);
        cmp("irq masked", 32'h0, {31'h0, irq});
        wr(A_IM, 32'h1F);
        repeat (3) @(posedge clk);
        cmp("irq unmasked", 32'h1, {31'h0, irq});
        wr(A_IS, 32'h1F);
        repeat (3) @(posedge clk);
        cmp("irq cleared", 32'h0, {31'h0, irq});
        wr(`TWF_OFF_CMD, {30'h0, `TWF_CMD_RESPOND});
        @(posedge clk);
        rd(A_ST, "data flag", 32'h0, 32'h5, 2'h0);
      end
    join
    cmp("data ack", 32'h0, {31'h0, ack});
    m.stop();
    wr(A_ST, 32'hB);
    wr(A_IS, 32'h1F);
    note("write");
    wr(`TWF_OFF_DATA, 32'h7F);
    fork
      begin
        m.start();
        m.xfer(8'h55, got, ack);
      end
      begin
        wait_st(`TWF_ST_ADDR_FLAG);
        rd(A_ST, "read status", 32'h96, 32'hFF, 2'h0);
        wr(A_ST, 32'hA);
      end
    join
    m.xfer(8'h00, got, ack);
    cmp("first read bit", 32'h0, {31'h0, got[7]});
    m.start();
    m.xfer(8'h20, got, ack);
    rd(A_ST, "coll after restart", 32'h8, 32'h8, 2'h0);
    m.stop();
    m.start();
    rd(A_ST, "coll after start", 32'h0, 32'h8, 2'h0);
    m.xfer(8'h20, got, ack);
    m.stop();
    wr(A_IS, 32'h1F);
    note("collision");
    wr(A_CT, 32'h3);
    m.start();
    m.float_high(40);
    rd(A_IS, "timeout", 32'h8, 32'h8, 2'h0);
    rd(A_ST, "bus after timeout", 32'h40, 32'hC0, 2'h0);
    m.stop();
    note("timeout");
    test_done();
  end
endmodule : twf_slave_tb_top
